// File: test_trigger_matching_window.sv
// Self-checking bench: controller and matcher joined by their link.
// Assumes the shared header and package are compiled before this file.
`include "trig_match_cfg.svh"
module test_trigger_matching_window
	import trig_match_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk;
	logic        sys_rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        ext_trigger;
	logic        ext_bunch_reset;
	logic        hit_valid;
	logic [4:0]  hit_channel;
	logic [7:0]  hit_fine;
	count_type   coarse_count;
	int          fails;
	int          num_checks;
	logic [31:0] w;
	logic [11:0] tag;
	logic [11:0] tag0;

	// ============================================================
	// Design under test
	trig_link_if u_trig_link_if ();
	trigger_matcher u_trigger_matcher (.core_clk, .sys_rst, .link(u_trig_link_if), .hit_valid,
		.hit_channel, .hit_fine, .coarse_count);
	trigger_controller u_trigger_controller (.core_clk, .sys_rst, .link(u_trig_link_if),
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.ext_trigger, .ext_bunch_reset);
	trig_match_checker u_trig_match_checker (.core_clk, .sys_rst, .coarse_count,
		.bunch_reset(u_trig_link_if.bunch_reset), .event_reset(u_trig_link_if.event_reset),
		.roll_over(u_trig_link_if.roll_over), .coarse_offset(u_trig_link_if.coarse_offset),
		.trigger_offset(u_trig_link_if.trigger_offset),
		.reject_offset(u_trig_link_if.reject_offset), .match_en(u_trig_link_if.match_en),
		.match_window(u_trig_link_if.match_window), .reject_en(u_trig_link_if.reject_en),
		.search_window(u_trig_link_if.search_window), .rd_data(u_trig_link_if.rd_data),
		.rd_valid(u_trig_link_if.rd_valid), .rd_ready(u_trig_link_if.rd_ready),
		.l1_drop(u_trig_link_if.l1_drop), .trig_drop(u_trig_link_if.trig_drop));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ============================================================
	// Tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon cycle; read data lands in w. Idle edge after, so strobes never re-toggle.
	// Only the watchdog ends a wait that never gets its answer.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge core_clk);
		end while (avs_waitrequest !== 1'b0);
		w = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic hits(input int n);
		for (int i = 0; i < n; i++) begin
			hit_valid <= 1'b1;
			hit_channel <= 5'(i);
			hit_fine <= 8'(i);
			@(posedge core_clk);
		end
		hit_valid <= 1'b0;
	endtask

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ============================================================
	// Tests
	initial begin
		sys_rst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		ext_trigger = 1'b0;
		ext_bunch_reset = 1'b0;
		hit_valid = 1'b0;
		hit_channel = 5'h00;
		hit_fine = 8'h00;
		fails = 0;
		num_checks = 0;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		bus(0, `REG_CTRL, 32'h0);
		check(w, 32'h0000000F);
		bus(0, `REG_ROLL, 32'h0);
		check(w, 32'h00000FFF);
		bus(0, `REG_LATENCY, 32'h0);
		check(w, 32'h00000194);
		bus(0, `REG_WINDOW, 32'h0);
		check(w, 32'h0000002B);
		bus(0, `REG_STATUS, 32'h0);
		check(w, 32'h0);
		bus(1, 5'h03, 32'hFFFFFFFF);
		bus(0, 5'h03, 32'h0);
		check(w, 32'h0);
		$display("Test reset values done");
		// Short cycle with an offset preset, so the wrap is reached quickly
		bus(1, `REG_ROLL, 32'h1FF);
		bus(1, `REG_COARSE, 32'h123);
		bus(1, `REG_CMD, 32'h2);
		repeat (250) @(posedge core_clk);
		check(32'(coarse_count < 12'h200), 32'h1);
		$display("Test counter wrap done");
		bus(1, `REG_ROLL, 32'hFFF);
		bus(1, `REG_COARSE, 32'h0);
		bus(1, `REG_LATENCY, 32'h28);
		bus(1, `REG_WINDOW, 32'h30);
		bus(0, `REG_STATUS, 32'h0);
		check(w & 32'h8, 32'h8);
		bus(1, `REG_CMD, 32'h1);
		repeat (20) @(posedge core_clk);
		bus(0, `REG_DATA, 32'h0);
		check(w, 32'h0);
		bus(1, `REG_WINDOW, 32'h5);
		bus(0, `REG_STATUS, 32'h0);
		check(w & 32'h8, 32'h0);
		$display("Test latency guard done");
		// Two triggers two cycles apart: windows overlap by four hits
		bus(1, `REG_CMD, 32'h6);
		repeat (4) @(posedge core_clk);
		hits(16);
		repeat (27) @(posedge core_clk);
		repeat (2) begin
			ext_trigger <= 1'b1;
			@(posedge core_clk);
			ext_trigger <= 1'b0;
			@(posedge core_clk);
		end
		repeat (60) @(posedge core_clk);
		for (int e = 0; e < 2; e++) begin
			bus(0, `REG_DATA, 32'h0);
			check(w >> 12, {12'h0, `WORD_HEADER, 4'h0, 12'(e)});
			tag = w[11:0];
			if (e == 0) tag0 = tag;
			check({20'h0, 12'(tag - tag0)}, 32'(2 * e));
			for (int i = 0; i < 6; i++) begin
				bus(0, `REG_DATA, 32'h0);
				check({w[31:28], 16'h0, 12'(w[11:0] - tag)}, {`WORD_HIT, 16'h0, 12'(i)});
			end
			bus(0, `REG_DATA, 32'h0);
			check(w, {`WORD_TRAILER, 4'h0, 12'(e), 12'h006});
		end
		bus(0, `REG_DATA, 32'h0);
		check(w, 32'h0);
		bus(0, `REG_STATUS, 32'h0);
		check(w, 32'h0);
		$display("Test overlapping events done");
		// Ungrouped stream fills the readout queue and the hit buffer; the last four are lost
		bus(1, `REG_CTRL, 32'h0);
		hits(100);
		repeat (80) @(posedge core_clk);
		bus(0, `REG_STATUS, 32'h0);
		check(w, 32'h3);
		for (int i = 0; i < 96; i++) begin
			bus(0, `REG_DATA, 32'h0);
			if (i == 0) tag0 = w[11:0];
			check({w[31:12], 12'(w[11:0] - tag0)}, {`WORD_HIT, 3'h0, 5'(i), 8'(i), 12'(i)});
		end
		bus(0, `REG_DATA, 32'h0);
		check(w, 32'h0);
		bus(1, `REG_CMD, 32'h4);
		bus(0, `REG_STATUS, 32'h0);
		check(w, 32'h0);
		$display("Test stream and fill done");
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run();
	end

endmodule // test_trigger_matching_window

// File: trig_link_if.sv
// Link between the trigger controller and the trigger matching device.
// Assumes both ends run on the same core clock.
interface trig_link_if;

	logic        trig_accept;
	logic        bunch_reset;
	logic        event_reset;
	logic [11:0] roll_over;
	logic [11:0] coarse_offset;
	logic [11:0] trigger_offset;
	logic [11:0] reject_offset;
	logic [11:0] match_window;
	logic [11:0] search_window;
	logic        match_en;
	logic        reject_en;
	logic        header_en;
	logic        trailer_en;
	logic [31:0] rd_data;
	logic        rd_valid;
	logic        rd_ready;
	logic        l1_drop;
	logic        trig_drop;

	modport dev (
		input  trig_accept, bunch_reset, event_reset, roll_over, coarse_offset,
		input  trigger_offset, reject_offset, match_window, search_window,
		input  match_en, reject_en, header_en, trailer_en, rd_ready,
		output rd_data, rd_valid, l1_drop, trig_drop
	);

	modport ctl (
		output trig_accept, bunch_reset, event_reset, roll_over, coarse_offset,
		output trigger_offset, reject_offset, match_window, search_window,
		output match_en, reject_en, header_en, trailer_en, rd_ready,
		input  rd_data, rd_valid, l1_drop, trig_drop
	);

endinterface

// File: trig_match_cfg.svh
// Constants shared by the trigger matching device and its controller.
// Assumes one core clock at 40 MHz and a synchronous active-high reset.
`ifndef TRIG_MATCH_CFG_SVH
`define TRIG_MATCH_CFG_SVH

// ============================================================
// Timing
`define CLK_PERIOD_NS      25
`define SEARCH_EXTRA       12'h008
`define REJECT_EXTRA       12'h004

// ============================================================
// Configuration reset values
`define ROLL_OVER_RST      12'hFFF
`define COARSE_OFF_RST     12'h000
`define LATENCY_RST        12'h194
`define MATCH_WIN_RST      12'h02B
`define SEARCH_ADD_RST     12'h000
`define CTRL_RST           4'hF

// ============================================================
// Control register bits
`define CTRL_MATCH_BIT     0
`define CTRL_REJECT_BIT    1
`define CTRL_HEADER_BIT    2
`define CTRL_TRAILER_BIT   3

// ============================================================
// Command register bits
`define CMD_TRIG_BIT       0
`define CMD_BUNCH_BIT      1
`define CMD_EVENT_BIT      2

// ============================================================
// Controller register byte offsets and the search field bit position in the window register
`define REG_CTRL           5'h00
`define REG_ROLL           5'h04
`define REG_COARSE         5'h08
`define REG_LATENCY        5'h0C
`define REG_WINDOW         5'h10
`define REG_CMD            5'h14
`define REG_STATUS         5'h18
`define REG_DATA           5'h1C
`define WIN_SEARCH_LSB     16

// ============================================================
// Readout word type codes
`define WORD_HEADER        4'h2
`define WORD_TRAILER       4'h3
`define WORD_HIT           4'h4

`endif

// File: trig_match_checker.sv
// Concurrent checks on the link between the trigger controller and matcher.
// Assumes one core clock and a synchronous active-high reset on both ends.
`include "trig_match_cfg.svh"
module trig_match_checker (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        bunch_reset,
	input wire logic        event_reset,
	input wire logic [11:0] roll_over,
	input wire logic [11:0] coarse_offset,
	input wire logic [11:0] trigger_offset,
	input wire logic [11:0] reject_offset,
	input wire logic [11:0] match_window,
	input wire logic [11:0] search_window,
	input wire logic        match_en,
	input wire logic        reject_en,
	input wire logic [31:0] rd_data,
	input wire logic        rd_valid,
	input wire logic        rd_ready,
	input wire logic        l1_drop,
	input wire logic        trig_drop,
	input wire logic [11:0] coarse_count
);

	// ============================================================
	// Expected reject preset, four cycles behind the trigger preset
	wire logic [12:0] wrap_v  = {1'b0, roll_over} + 13'h001;
	wire logic [12:0] rej_exp = (trigger_offset >= 12'h004) ?
		{1'b0, trigger_offset} - 13'h004 : {1'b0, trigger_offset} + wrap_v - 13'h004;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// ============================================================
	// Counters
	// Reset is sampled too, since the attempt at the release edge is not disabled
	count_step_a: assert property (!sys_rst && !bunch_reset && coarse_count < roll_over |=>
		coarse_count == $past(coarse_count) + 12'h001) else $error("coarse count did not step");
	count_wrap_a: assert property (!bunch_reset && coarse_count == roll_over |=>
		coarse_count == 12'h000) else $error("coarse count did not wrap to zero");
	preset_load_a: assert property (bunch_reset |=> coarse_count == $past(coarse_offset))
		else $error("coarse preset not loaded");
	reject_off_a: assert property ($stable(trigger_offset) && $stable(reject_offset)
		&& $stable(roll_over) && trigger_offset != reject_offset |-> reject_offset == rej_exp[11:0])
		else $error("reject preset not four cycles behind trigger preset");
	search_width_a: assert property (reject_en && $stable(match_window)
		&& $stable(search_window) |-> search_window >= match_window + 12'h008)
		else $error("search window narrower than match window plus eight");
	reject_on_a: assert property (match_en [*3] |-> reject_en)
		else $error("reject off while matching");

	// ============================================================
	// Readout and loss flags
	pop_valid_a: assert property (rd_ready |-> rd_valid)
		else $error("pop of an empty readout queue");
	pop_pulse_a: assert property (rd_ready |=> !rd_ready)
		else $error("pop held longer than one cycle");
	word_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
		else $error("readout word changed before pop");
	word_type_a: assert property (rd_valid |-> rd_data[31:28] inside
		{`WORD_HEADER, `WORD_TRAILER, `WORD_HIT}) else $error("unknown readout word type");
	hit_drop_a: assert property (l1_drop && !event_reset |=> l1_drop)
		else $error("hit loss flag cleared by itself");
	trig_drop_a: assert property (trig_drop && !event_reset |=> trig_drop)
		else $error("trigger loss flag cleared by itself");

endmodule // trig_match_checker

// File: trig_match_pkg.sv
// Types and helper arithmetic for the trigger matching blocks.
// Assumes counters of 12 bits that wrap at a programmed roll-over.
package trig_match_pkg;

	typedef logic [11:0] count_type;
	typedef logic [12:0] wrap_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_HEAD = 4'b0010,
		ST_SCAN = 4'b0100,
		ST_TAIL = 4'b1000
	} match_state_type;

	// Difference a - b modulo the counter wrap range
	function automatic count_type mod_sub(input count_type a, input count_type b,
			input wrap_type wrap);
		wrap_type d;
		d = {1'b0, a} - {1'b0, b};
		if (a < b) begin
			d = d + wrap;
		end
		return d[11:0];
	endfunction

endpackage

// File: trigger_controller.sv
// Trigger system and readout controller end, with an Avalon-MM slave.
// Assumes external trigger and bunch inputs already synchronous to core_clk.
module trigger_controller
	import trig_match_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	trig_link_if.ctl         link,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ext_trigger,
	input  wire logic        ext_bunch_reset
);
	`include "trig_match_cfg.svh"

	// ============================================================
	// Bus slave
	logic [3:0]  ctrl_reg;
	count_type   roll_reg;
	count_type   coff_reg;
	count_type   lat_reg;
	count_type   match_reg;
	count_type   sadd_reg;
	logic        wait_reg;
	logic        pop_reg;
	logic [31:0] rdata_reg;

	wire        req     = avs_read || avs_write;
	wire        acc     = req && !wait_reg;
	wire        wr_acc  = acc && avs_write;
	wire        lat_bad = (lat_reg <= match_reg);
	wire [31:0] status  = {28'h0, lat_bad, link.trig_drop, link.l1_drop, link.rd_valid};
	wire [31:0] rd_mux  =
		(avs_address == `REG_CTRL)    ? {28'h0, ctrl_reg} :
		(avs_address == `REG_ROLL)    ? {20'h0, roll_reg} :
		(avs_address == `REG_COARSE)  ? {20'h0, coff_reg} :
		(avs_address == `REG_LATENCY) ? {20'h0, lat_reg} :
		(avs_address == `REG_WINDOW)  ? {4'h0, sadd_reg, 4'h0, match_reg} :
		(avs_address == `REG_STATUS)  ? status :
		(avs_address == `REG_DATA)    ? (link.rd_valid ? link.rd_data : 32'h0) :
		32'h0;

	// A pop still in flight holds off the next answer so data is never stale
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wait_reg  <= 1'b1;
			pop_reg   <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			wait_reg <= !(req && wait_reg && !pop_reg);
			pop_reg  <= acc && avs_read && (avs_address == `REG_DATA) && link.rd_valid;
			if (req && wait_reg && !pop_reg) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg  <= `CTRL_RST;
			roll_reg  <= `ROLL_OVER_RST;
			coff_reg  <= `COARSE_OFF_RST;
			lat_reg   <= `LATENCY_RST;
			match_reg <= `MATCH_WIN_RST;
			sadd_reg  <= `SEARCH_ADD_RST;
		end else if (wr_acc) begin
			if (avs_address == `REG_CTRL) begin
				ctrl_reg <= avs_writedata[3:0];
			end
			if (avs_address == `REG_ROLL) begin
				roll_reg <= avs_writedata[11:0];
			end
			if (avs_address == `REG_COARSE) begin
				coff_reg <= avs_writedata[11:0];
			end
			if (avs_address == `REG_LATENCY) begin
				lat_reg <= avs_writedata[11:0];
			end
			if (avs_address == `REG_WINDOW) begin
				match_reg <= avs_writedata[11:0];
				sadd_reg  <= avs_writedata[`WIN_SEARCH_LSB+11:`WIN_SEARCH_LSB];
			end
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign link.rd_ready   = pop_reg;

	// ============================================================
	// Trigger, bunch and event pulses
	logic ext_trig_d_reg;
	logic ext_bunch_d_reg;
	logic trig_reg;
	logic bunch_reg;
	logic event_reg;

	wire cmd_wr = wr_acc && (avs_address == `REG_CMD);

	// Edge shaping gives one period per trigger at a fixed one-cycle delay
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ext_trig_d_reg  <= 1'b0;
			ext_bunch_d_reg <= 1'b0;
			trig_reg        <= 1'b0;
			bunch_reg       <= 1'b0;
			event_reg       <= 1'b0;
		end else begin
			ext_trig_d_reg  <= ext_trigger;
			ext_bunch_d_reg <= ext_bunch_reset;
			trig_reg  <= !lat_bad && ((ext_trigger && !ext_trig_d_reg)
					|| (cmd_wr && avs_writedata[`CMD_TRIG_BIT]));
			bunch_reg <= (ext_bunch_reset && !ext_bunch_d_reg)
					|| (cmd_wr && avs_writedata[`CMD_BUNCH_BIT]);
			event_reg <= cmd_wr && avs_writedata[`CMD_EVENT_BIT];
		end
	end

	assign link.trig_accept = trig_reg;
	assign link.bunch_reset = bunch_reg;
	assign link.event_reset = event_reg;

	// ============================================================
	// Derived counter presets and windows
	count_type trig_off_reg;
	count_type rej_off_reg;
	count_type search_reg;
	logic      rej_en_reg;

	wire wrap_type wrap = {1'b0, roll_reg} + 13'h0001;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trig_off_reg <= 12'h000;
			rej_off_reg  <= 12'h000;
			search_reg   <= 12'h000;
			rej_en_reg   <= 1'b0;
		end else begin
			trig_off_reg <= mod_sub(coff_reg, lat_reg, wrap);
			rej_off_reg  <= mod_sub(coff_reg, lat_reg + `REJECT_EXTRA, wrap);
			search_reg   <= match_reg + `SEARCH_EXTRA + sadd_reg;
			rej_en_reg   <= ctrl_reg[`CTRL_REJECT_BIT] || ctrl_reg[`CTRL_MATCH_BIT];
		end
	end

	assign link.roll_over      = roll_reg;
	assign link.coarse_offset  = coff_reg;
	assign link.trigger_offset = trig_off_reg;
	assign link.reject_offset  = rej_off_reg;
	assign link.match_window   = match_reg;
	assign link.search_window  = search_reg;
	assign link.match_en       = ctrl_reg[`CTRL_MATCH_BIT];
	assign link.reject_en      = rej_en_reg;
	assign link.header_en      = ctrl_reg[`CTRL_HEADER_BIT];
	assign link.trailer_en     = ctrl_reg[`CTRL_TRAILER_BIT];
endmodule // trigger_controller

// File: trigger_matcher.sv
// Trigger matching device: counters, hit buffer, trigger queue, matching and
// a readout FIFO. Assumes hits and trigger accepts synchronous to core_clk.

// ============================================================
// Readout FIFO
module data_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg;
	logic [AW:0]      rd_reg;

	wire         push = in_valid && in_ready;
	wire         pop  = out_valid && out_ready;
	wire [AW:0]  used = wr_reg - rd_reg;

	assign in_ready  = (used != DEPTH[AW:0]);
	assign out_valid = (used != '0);
	assign out_data  = mem[rd_reg[AW-1:0]];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_reg + {{AW{1'b0}}, push};
			rd_reg <= rd_reg + {{AW{1'b0}}, pop};
		end
	end
endmodule // data_fifo

// ============================================================
// Trigger matching device
module trigger_matcher
	import trig_match_pkg::*;
#(
	parameter int L1_DEPTH   = 64,
	parameter int TQ_DEPTH   = 16,
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	trig_link_if.dev        link,
	input  wire logic       hit_valid,
	input  wire logic [4:0] hit_channel,
	input  wire logic [7:0] hit_fine,
	output count_type       coarse_count
);
	localparam int LW = $clog2(L1_DEPTH);
	localparam int QW = $clog2(TQ_DEPTH);

	`include "trig_match_cfg.svh"

	// ============================================================
	// Time counters
	count_type coarse_reg;
	count_type trig_cnt_reg;
	count_type rej_cnt_reg;

	wire wrap_type  wrap = {1'b0, link.roll_over} + 13'h0001;
	wire count_type half = wrap[12:1];

	function automatic count_type cnt_step(input count_type c, input count_type roll);
		return (c == roll) ? 12'h000 : c + 12'h001;
	endfunction

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			coarse_reg   <= 12'h000;
			trig_cnt_reg <= 12'h000;
			rej_cnt_reg  <= 12'h000;
		end else if (link.bunch_reset) begin
			coarse_reg   <= link.coarse_offset;
			trig_cnt_reg <= link.trigger_offset;
			rej_cnt_reg  <= link.reject_offset;
		end else begin
			coarse_reg   <= cnt_step(coarse_reg, link.roll_over);
			trig_cnt_reg <= cnt_step(trig_cnt_reg, link.roll_over);
			rej_cnt_reg  <= cnt_step(rej_cnt_reg, link.roll_over);
		end
	end

	assign coarse_count = coarse_reg;

	// ============================================================
	// Level-one hit buffer: {channel, fine, coarse time}
	logic [24:0] l1_mem [L1_DEPTH];
	logic [LW:0] l1_wr_reg;
	logic [LW:0] l1_tail_reg;
	logic        l1_drop_reg;

	wire [LW:0]  l1_used  = l1_wr_reg - l1_tail_reg;
	wire         l1_full  = (l1_used == L1_DEPTH[LW:0]);
	wire         l1_empty = (l1_used == '0);
	wire         l1_push  = hit_valid && !l1_full;
	wire [24:0]  head_ent = l1_mem[l1_tail_reg[LW-1:0]];
	wire count_type head_age = mod_sub(rej_cnt_reg, head_ent[11:0], wrap);

	always_ff @(posedge core_clk) begin
		if (l1_push) begin
			l1_mem[l1_wr_reg[LW-1:0]] <= {hit_channel, hit_fine, coarse_reg};
		end
	end

	// ============================================================
	// Trigger queue of trigger time tags
	count_type   tq_mem [TQ_DEPTH];
	logic [QW:0] tq_wr_reg;
	logic [QW:0] tq_rd_reg;
	logic        tq_drop_reg;

	wire [QW:0] tq_used  = tq_wr_reg - tq_rd_reg;
	wire        tq_full  = (tq_used == TQ_DEPTH[QW:0]);
	wire        tq_empty = (tq_used == '0);
	wire        tq_push  = link.trig_accept && !tq_full;

	always_ff @(posedge core_clk) begin
		if (tq_push) begin
			tq_mem[tq_wr_reg[QW-1:0]] <= trig_cnt_reg;
		end
	end

	// ============================================================
	// Matching state machine
	match_state_type state_reg;
	match_state_type state_next;
	count_type       tag_reg;
	count_type       evid_reg;
	count_type       nhit_reg;
	logic [LW:0]     scan_reg;
	logic [LW:0]     stop_reg;

	wire        fifo_ready;
	wire        st_idle  = (state_reg == ST_IDLE);
	wire        st_head  = (state_reg == ST_HEAD);
	wire        st_scan  = (state_reg == ST_SCAN);
	wire        st_tail  = (state_reg == ST_TAIL);
	wire [24:0] scan_ent = l1_mem[scan_reg[LW-1:0]];
	wire count_type scan_d = mod_sub(scan_ent[11:0], tag_reg, wrap);
	wire        in_win   = (scan_d <= link.match_window);
	wire        past_win = (scan_d > link.search_window) && (scan_d < half);
	wire        scan_end = (scan_reg == stop_reg) || past_win;

	// Without matching, hits stream straight out in arrival order
	wire        pass_out = st_idle && !link.match_en && !l1_empty;
	wire        start    = st_idle && link.match_en && !tq_empty;
	// Stale hits go only while idle so a scan never sees its entries reused
	wire        reject   = st_idle && link.match_en && link.reject_en && !l1_empty
				&& (head_age != 12'h000) && (head_age < half);
	wire        hit_out  = st_scan && !scan_end && in_win;
	wire        hdr_out  = st_head && link.header_en;
	wire        trl_out  = st_tail && link.trailer_en;

	wire        push_valid = pass_out || hit_out || hdr_out || trl_out;
	wire        pushed     = push_valid && fifo_ready;
	wire        head_done  = st_head && (!link.header_en || fifo_ready);
	wire        tail_done  = st_tail && (!link.trailer_en || fifo_ready);
	wire        scan_step  = st_scan && !scan_end && (!in_win || fifo_ready);

	wire [24:0] out_ent = pass_out ? head_ent : scan_ent;
	wire [31:0] hit_word = {`WORD_HIT, 3'h0, out_ent};
	wire [31:0] hdr_word = {`WORD_HEADER, 4'h0, evid_reg, tag_reg};
	wire [31:0] trl_word = {`WORD_TRAILER, 4'h0, evid_reg, nhit_reg};
	wire [31:0] push_data = hdr_out ? hdr_word : (trl_out ? trl_word : hit_word);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (start) begin
					state_next = ST_HEAD;
				end
			end
			ST_HEAD: begin
				if (head_done) begin
					state_next = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (scan_end) begin
					state_next = ST_TAIL;
				end
			end
			ST_TAIL: begin
				if (tail_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			tag_reg   <= 12'h000;
			scan_reg  <= '0;
			stop_reg  <= '0;
			nhit_reg  <= 12'h000;
		end else begin
			state_reg <= state_next;
			if (start) begin
				tag_reg  <= tq_mem[tq_rd_reg[QW-1:0]];
				scan_reg <= l1_tail_reg;
				stop_reg <= l1_wr_reg;
				nhit_reg <= 12'h000;
			end else begin
				scan_reg <= scan_reg + {{LW{1'b0}}, scan_step};
				nhit_reg <= nhit_reg + {11'h000, hit_out && pushed};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			l1_wr_reg   <= '0;
			l1_tail_reg <= '0;
			tq_wr_reg   <= '0;
			tq_rd_reg   <= '0;
			evid_reg    <= 12'h000;
			l1_drop_reg <= 1'b0;
			tq_drop_reg <= 1'b0;
		end else begin
			l1_wr_reg   <= l1_wr_reg + {{LW{1'b0}}, l1_push};
			l1_tail_reg <= l1_tail_reg + {{LW{1'b0}}, (pass_out && fifo_ready) || reject};
			tq_wr_reg   <= tq_wr_reg + {{QW{1'b0}}, tq_push};
			tq_rd_reg   <= tq_rd_reg + {{QW{1'b0}}, start};
			// A drop in the clearing cycle is kept
			l1_drop_reg <= (hit_valid && l1_full) || (l1_drop_reg && !link.event_reset);
			tq_drop_reg <= (link.trig_accept && tq_full)
					|| (tq_drop_reg && !link.event_reset);
			if (link.event_reset) begin
				evid_reg <= 12'h000;
			end else if (tail_done) begin
				evid_reg <= evid_reg + 12'h001;
			end
		end
	end

	assign link.l1_drop   = l1_drop_reg;
	assign link.trig_drop = tq_drop_reg;

	// ============================================================
	// Readout buffer, drained by the controller
	data_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.in_valid  (push_valid),
		.in_ready  (fifo_ready),
		.in_data   (push_data),
		.out_valid (link.rd_valid),
		.out_ready (link.rd_ready),
		.out_data  (link.rd_data)
	);
endmodule // trigger_matcher
